// File: smc_core.sv
`timescale 1ns/1ns
module smc_core
    import smc_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    smc_link_if.core         LINK,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic        WAKE_I,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic [31:0]      PRDATA_O
);

    typedef struct packed {
        logic       halt;
        logic       stop;
        logic       wr;
        logic       rd;
        logic [7:0] data;
        logic [31:0] prdata;
    } smc_core_state_t;

    smc_core_state_t s_q;
    smc_core_state_t s_d;
    logic            acc;
    logic            hit;

    // =========================================================
    // APB slave, zero-wait
    // =========================================================
    assign acc = PSEL_I && PENABLE_I;
    assign hit = (PADDR_I == SMC_CTRL_OFS) || (PADDR_I == SMC_STAT_OFS)
                 || (PADDR_I == SMC_DATA_OFS);

    always_comb
    begin
        s_d      = s_q;
        s_d.halt = 1'b0;
        s_d.stop = 1'b0;
        s_d.wr   = 1'b0;
        s_d.rd   = 1'b0;
        if (acc && PWRITE_I && PADDR_I == SMC_CTRL_OFS)
        begin
            // Converter and main-clocked peripherals are software's job
            s_d.halt = PWDATA_I[SMC_CMD_HALT];
            s_d.stop = PWDATA_I[SMC_CMD_STOP];
            s_d.wr   = PWDATA_I[SMC_CMD_WRSEL];
            s_d.rd   = PWDATA_I[SMC_CMD_RDSEL];
        end
        if (acc && PWRITE_I && PADDR_I == SMC_DATA_OFS)
        begin
            s_d.data = PWDATA_I[7:0];
        end
        if (acc && !PWRITE_I)
        begin
            case (PADDR_I)
                SMC_STAT_OFS: s_d.prdata = {29'h0, LINK.busy,
                                            LINK.cpu_clk_en, 1'b0};
                SMC_DATA_OFS: s_d.prdata = {24'h0, LINK.rdata};
                default:      s_d.prdata = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign PREADY_O       = 1'b1;
    assign PSLVERR_O      = acc && !hit;
    assign PRDATA_O       = s_q.prdata;
    assign LINK.halt_exec = s_q.halt;
    assign LINK.stop_exec = s_q.stop;
    assign LINK.sel_wr    = s_q.wr;
    assign LINK.sel_rd    = s_q.rd;
    assign LINK.addr      = SMC_SETTLE_ADDR;
    assign LINK.wdata     = s_q.data;
    assign LINK.wake_req  = WAKE_I;

endmodule : smc_core

// File: smc_device.sv
// Added by the designer: the mode sequencer and light-sleep peripheral gating behind the link.
`timescale 1ns/1ns
module smc_device
    import smc_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    smc_link_if.device      LINK,
    input  wire logic       ON_SUB_CLK_I,
    input  wire logic       IRQ_PENDING_I,
    input  wire logic       OSC_RUNNING_I,
    input  wire logic       TMR_EXT_SEL_I,
    input  wire logic       SIO_EXT_SEL_I,
    input  wire logic [1:0] INTP_CLK_SEL_I,
    output logic            MAIN_OSC_EN_O,
    output logic            SLEEPING_O,
    output logic            TMR_RUN_O,
    output logic            SIO_RUN_O,
    output logic            INTP_RUN_O,
    output logic [2:0]      MODE_O
);

    typedef struct packed {
        smc_mode_t              mode;
        logic [SMC_SEL_W-1:0]   sel;
        logic [SMC_CNT_W-1:0]   cnt;
        logic [7:0]             rdata;
        logic                   main_stopped;
    } smc_dev_state_t;

    smc_dev_state_t s_q;
    smc_dev_state_t s_d;
    logic [4:0]     exp_w;

    // =========================================================
    // Wait length decode
    // =========================================================
    always_comb
    begin
        case (s_q.sel)
            3'h0:    exp_w = SMC_EXP_SEL0;
            3'h1:    exp_w = SMC_EXP_SEL1;
            3'h2:    exp_w = SMC_EXP_SEL2;
            3'h3:    exp_w = SMC_EXP_SEL3;
            default: exp_w = SMC_EXP_SEL4; // Prohibited codes fall to longest
        endcase
    end

    // =========================================================
    // Mode sequencer
    // =========================================================
    always_comb
    begin
        s_d = s_q;
        // Only the byte-wide select port can change the field
        if (LINK.sel_wr && LINK.addr == SMC_SETTLE_ADDR)
        begin
            s_d.sel = LINK.wdata[SMC_SEL_W-1:0];
        end
        if (LINK.sel_rd && LINK.addr == SMC_SETTLE_ADDR)
        begin
            s_d.rdata = {5'h00, s_q.sel};
        end
        case (s_q.mode)
            SMC_RUN:
            begin
                if (LINK.stop_exec && !ON_SUB_CLK_I)
                begin
                    if (IRQ_PENDING_I)
                    begin
                        // Oscillator never stops, but the wait still applies
                        s_d.mode = SMC_SETTLE;
                        s_d.cnt  = '0;
                    end
                    else
                    begin
                        s_d.mode = SMC_STOP;
                        s_d.main_stopped = 1'b1;
                    end
                end
                else if (LINK.halt_exec)
                begin
                    s_d.mode = SMC_HALT;
                end
            end
            SMC_HALT:
            begin
                if (LINK.wake_req)
                begin
                    s_d.mode = SMC_RUN;
                end
            end
            SMC_STOP:
            begin
                if (LINK.wake_req || IRQ_PENDING_I)
                begin
                    s_d.mode = SMC_OSC_START;
                    s_d.main_stopped = 1'b0;
                end
            end
            SMC_OSC_START:
            begin
                // Start-up time is uncounted, so wait for oscillation
                if (OSC_RUNNING_I)
                begin
                    s_d.mode = SMC_SETTLE;
                    s_d.cnt  = '0;
                end
            end
            SMC_SETTLE:
            begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == (SMC_CNT_W'(1) << exp_w) - 1'b1)
                begin
                    s_d.mode = SMC_RUN;
                end
            end
            default:
            begin
                s_d.mode = SMC_RUN;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            s_q.mode         <= SMC_RUN;
            s_q.sel          <= SMC_SETTLE_RST[SMC_SEL_W-1:0];
            s_q.cnt          <= '0;
            s_q.rdata        <= '0;
            s_q.main_stopped <= 1'b0;
        end
        else
        begin
            s_q <= s_d; // Sleep touches no other state
        end
    end

    // =========================================================
    // Outputs and light-sleep peripheral gating
    // =========================================================
    assign LINK.rdata      = s_q.rdata;
    assign LINK.busy       = (s_q.mode != SMC_RUN);
    assign LINK.cpu_clk_en = (s_q.mode == SMC_RUN);
    assign MAIN_OSC_EN_O   = !s_q.main_stopped;
    assign SLEEPING_O      = (s_q.mode != SMC_RUN);
    assign MODE_O          = s_q.mode;

    // Halt: TMR stops on sub clock with main osc off, SIO whenever main osc off, unless external; INTP runs only on main clock at /64 or /128
    assign TMR_RUN_O  = !(s_q.mode == SMC_HALT && ON_SUB_CLK_I
                          && !OSC_RUNNING_I) || TMR_EXT_SEL_I;
    assign SIO_RUN_O  = !(s_q.mode == SMC_HALT && !OSC_RUNNING_I)
                        || SIO_EXT_SEL_I;
    assign INTP_RUN_O = (s_q.mode != SMC_HALT)
                        || (!ON_SUB_CLK_I
                            && (INTP_CLK_SEL_I == SMC_INTP_DIV64
                                || INTP_CLK_SEL_I == SMC_INTP_DIV128));

endmodule : smc_device

// File: smc_link_if.sv
`timescale 1ns/1ns
interface smc_link_if;
    logic        halt_exec;
    logic        stop_exec;
    logic        wake_req;
    logic        sel_wr;
    logic        sel_rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        busy;
    logic        cpu_clk_en;

    modport device (input halt_exec, stop_exec, wake_req, sel_wr, sel_rd,
                    addr, wdata,
                    output rdata, busy, cpu_clk_en);
    modport core (output halt_exec, stop_exec, wake_req, sel_wr, sel_rd,
                  addr, wdata,
                  input rdata, busy, cpu_clk_en);
endinterface : smc_link_if

// File: smc_pkg.sv
package smc_pkg;

    // =========================================================
    // Register map and field layout
    // =========================================================
    localparam logic [15:0] SMC_SETTLE_ADDR  = 16'hfffa;
    localparam logic [7:0]  SMC_SETTLE_RST   = 8'h04;
    localparam int          SMC_SEL_W        = 3;
    localparam logic [2:0]  SMC_SEL_MAX      = 3'h4;

    // =========================================================
    // Wait lengths as powers of two of the main clock
    // =========================================================
    localparam int          SMC_CNT_W        = 18;
    localparam logic [4:0]  SMC_EXP_SEL0     = 5'h0c;
    localparam logic [4:0]  SMC_EXP_SEL1     = 5'h0e;
    localparam logic [4:0]  SMC_EXP_SEL2     = 5'h0f;
    localparam logic [4:0]  SMC_EXP_SEL3     = 5'h10;
    localparam logic [4:0]  SMC_EXP_SEL4     = 5'h11;

    // =========================================================
    // Controller registers reached over APB
    // =========================================================
    localparam logic [7:0]  SMC_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  SMC_STAT_OFS     = 8'h04;
    localparam logic [7:0]  SMC_DATA_OFS     = 8'h08;
    localparam int          SMC_CMD_HALT     = 0;
    localparam int          SMC_CMD_STOP     = 1;
    localparam int          SMC_CMD_WRSEL    = 2;
    localparam int          SMC_CMD_RDSEL    = 3;

    // =========================================================
    // Peripheral clock selections seen in light sleep
    // =========================================================
    localparam logic [1:0]  SMC_INTP_DIV64   = 2'h2;
    localparam logic [1:0]  SMC_INTP_DIV128  = 2'h3;

    typedef enum logic [2:0] {
        SMC_RUN,
        SMC_HALT,
        SMC_STOP,
        SMC_OSC_START,
        SMC_SETTLE
    } smc_mode_t;

endpackage : smc_pkg

// File: smc_sva.sv
`timescale 1ns/1ns
module smc_sva
    import smc_pkg::*;
(
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic        halt_exec,
    input wire logic        stop_exec,
    input wire logic        wake_req,
    input wire logic        sel_wr,
    input wire logic        sel_rd,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        busy,
    input wire logic        cpu_clk_en
);
    // ==========================================
    // Shadow of the wait select
    // ==========================================
    logic [2:0] sel_q;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            sel_q <= SMC_SETTLE_RST[2:0];
        else if (sel_wr)
            sel_q <= wdata[2:0];
    end
    clk_gate_a: assert property (cpu_clk_en != busy)
        else $error("cpu clock enable disagrees with busy");
    halt_entry_a: assert property (halt_exec && !busy |=> busy)
        else $error("halt did not gate the cpu clock");
    halt_hold_a: assert property (
        halt_exec && !busy ##1 (!wake_req) [*4] |-> busy)
        else $error("halt left without wake");
    sleep_cause_a: assert property (
        $rose(busy) |-> $past(halt_exec || stop_exec))
        else $error("sleep without an instruction");
    wake_a: assert property (
        halt_exec && !busy ##1 wake_req |=> !busy)
        else $error("wake did not end halt");
    sel_read_a: assert property (
        sel_rd |=> rdata == {5'h00, $past(sel_q)})
        else $error("wait select read back wrong");
    rdata_hold_a: assert property (
        sel_rd ##1 !sel_rd |=> $stable(rdata))
        else $error("read data changed without a read");
    addr_fixed_a: assert property (
        sel_wr || sel_rd |-> addr == SMC_SETTLE_ADDR)
        else $error("wait select at wrong address");
    cover property (halt_exec);
    cover property (stop_exec);
    cover property (sel_rd);
    cover property (busy && wake_req);
endmodule : smc_sva

// File: standby_mode_controller_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== ((e))) begin \
    miscompares++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module standby_mode_controller_tb
    import smc_pkg::*;
;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        wake = 0, on_sub = 0, irq = 0, osc_run = 1, rd_chk = 0;
    logic        tmr_ext = 0, sio_ext = 0, err;
    logic [1:0]  intp_sel = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rnd, e_v, m_v;
    logic [31:0] exp_q[$], msk_q[$];
    wire         pready, pslverr, osc_en, sleeping, tmr_run, sio_run, intp_run;
    wire  [31:0] prdata;
    wire  [2:0]  mode;
    int          miscompares = 0, total_checks = 0, n;
    always #5 ref_clk = ~ref_clk;
    smc_link_if link ();
    smc_device u_smc_device (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK(link),
        .ON_SUB_CLK_I(on_sub), .IRQ_PENDING_I(irq), .OSC_RUNNING_I(osc_run),
        .TMR_EXT_SEL_I(tmr_ext), .SIO_EXT_SEL_I(sio_ext),
        .INTP_CLK_SEL_I(intp_sel), .MAIN_OSC_EN_O(osc_en),
        .SLEEPING_O(sleeping), .TMR_RUN_O(tmr_run), .SIO_RUN_O(sio_run),
        .INTP_RUN_O(intp_run), .MODE_O(mode));
    smc_core u_smc_core (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK(link),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .WAKE_I(wake),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata));
    smc_sva u_smc_sva (.REF_CLK_I(ref_clk), .RST_I(rst),
        .halt_exec(link.halt_exec), .stop_exec(link.stop_exec),
        .wake_req(link.wake_req), .sel_wr(link.sel_wr),
        .sel_rd(link.sel_rd), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .busy(link.busy), .cpu_clk_en(link.cpu_clk_en));
    // ==========================================
    // Read data is registered, so it is checked one edge after access
    // ==========================================
    always @(posedge ref_clk)
    begin
        if (rd_chk)
        begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CHK("prdata", e_v, prdata & m_v)
        end
        rd_chk <= psel && penable && !pwrite;
    end
    task automatic test_done();
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        repeat (2)
        begin
            exp_q.push_back(e);
            msk_q.push_back(m);
            apb(1'b0, a, 32'h0);
        end
    endtask : rd
    task automatic rdsel(input logic [2:0] c);
        apb(1'b1, SMC_CTRL_OFS, 32'h8);
        repeat (3) @(posedge ref_clk);
        rd(SMC_DATA_OFS, {29'h0, c}, 32'hff);
    endtask : rdsel
    task automatic cmd(input logic [31:0] d, input logic [2:0] m, o);
        apb(1'b1, SMC_CTRL_OFS, d);
        repeat (3) @(posedge ref_clk);
        `CHK("mode", m, mode)
        `CHK("osc_en", o[0], osc_en)
    endtask : cmd
    // Counts cycles spent settling; the oscillator must stay enabled
    task automatic settle(input int e);
        int s;
        n = 0;
        s = 0;
        for (int i = 0; i < 5000 && (n == 0 || mode !== SMC_RUN); i++)
        begin
            @(negedge ref_clk);
            n += int'(mode === SMC_SETTLE);
            s += int'(osc_en !== 1'b1);
        end
        @(posedge ref_clk);
        `CHK("settle", e, n)
        `CHK("osc_stop", 0, s)
    endtask : settle
    // Two 4096-cycle waits dominate; 20000 cycles is ample
    initial
    begin
        #200us;
        miscompares++;
        test_done();
    end
    initial
    begin
        rnd = $urandom(28);
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdsel(3'h4);
        rd(SMC_STAT_OFS, 32'h2, 32'h6);
        for (int c = 4; c >= 0; c--)
        begin
            rnd = $urandom();
            apb(1'b1, SMC_DATA_OFS, {24'h0, rnd[7:3], 3'(c)});
            apb(1'b1, SMC_CTRL_OFS, 32'h4);
            rdsel(3'(c));
        end
        cmd(32'h1, SMC_HALT, 3'h1);
        `CHK("sleeping", 1'b1, sleeping)
        rd(SMC_STAT_OFS, 32'h4, 32'h6);
        repeat (32)
        begin
            rnd = $urandom();
            {on_sub, osc_run, tmr_ext, sio_ext, intp_sel} <= rnd[5:0];
            @(negedge ref_clk);
            `CHK("tmr", !(rnd[5] && !rnd[4]) || rnd[3], tmr_run)
            `CHK("sio", rnd[4] || rnd[2], sio_run)
            `CHK("intp", !rnd[5] && rnd[1], intp_run)
            @(posedge ref_clk);
        end
        {on_sub, osc_run} <= 2'h1;
        wake <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("mode", SMC_RUN, mode)
        wake <= 1'b0;
        on_sub <= 1'b1;
        cmd(32'h2, SMC_RUN, 3'h1);
        on_sub <= 1'b0;
        irq <= 1'b1;
        apb(1'b1, SMC_CTRL_OFS, 32'h2);
        settle(1 << SMC_EXP_SEL0);
        irq <= 1'b0;
        wake <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wake <= 1'b0;
        cmd(32'h2, SMC_STOP, 3'h0);
        osc_run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wake <= 1'b1;
        repeat (50) @(posedge ref_clk);
        `CHK("mode", SMC_OSC_START, mode)
        `CHK("osc_en", 1'b1, osc_en)
        osc_run <= 1'b1;
        wake <= 1'b0;
        settle(1 << SMC_EXP_SEL0);
        rdsel(3'h0);
        apb(1'b1, 8'h0c, 32'h1);
        `CHK("pslverr", 1'b1, err)
        `CHK("mode", SMC_RUN, mode)
        test_done();
    end
endmodule : standby_mode_controller_tb
